//--- hw/ldemu_pkg.sv
// Package: offsets, field positions, reset values and carrier types for ldemu
package ldemu_pkg;

    // ==========================================================
    // Register offsets (memory-mapped addresses)
    localparam logic [12:0] OFF_FEATURE_RD  = 13'h1FCA;
    localparam logic [12:0] OFF_GC_INDEX    = 13'h1FCE;
    localparam logic [12:0] OFF_GC_DATA     = 13'h1FCF;
    localparam logic [12:0] OFF_MODE_CTL    = 13'h1FD8;
    localparam logic [12:0] OFF_COLOUR_SEL  = 13'h1FD9;
    localparam logic [12:0] OFF_STATUS_ONE  = 13'h1FDA;
    localparam logic [12:0] OFF_LPEN_CLEAR  = 13'h1FDB;
    localparam logic [12:0] OFF_LPEN_SET    = 13'h1FDC;
    localparam logic [12:0] OFF_AUX_INDEX   = 13'h1FDE;
    localparam logic [12:0] OFF_AUX_DATA    = 13'h1FDF;

    // ==========================================================
    // Indices behind the shared data ports
    localparam logic [3:0] GC_IDX_BIT_MASK  = 4'h8;
    localparam logic [3:0] AUX_IDX_MODE     = 4'h0;
    localparam logic [3:0] AUX_IDX_EXTFN    = 4'h1;
    localparam logic [3:0] AUX_IDX_EMUL     = 4'h2;
    localparam logic [3:0] AUX_IDX_STORE    = 4'h4;

    // ==========================================================
    // Field positions
    localparam int CM_BLINK    = 5;
    localparam int CM_HIRES    = 4;
    localparam int CM_DISPEN   = 3;
    localparam int CM_MONO     = 2;
    localparam int CM_GFX      = 1;
    localparam int CS_ALTPAL   = 5;
    localparam int CS_INTPAL   = 4;
    localparam int EC_BLANK    = 5;
    localparam int EC_PALDIS   = 4;
    localparam int EC_BORDER   = 3;
    localparam int MC_SPEED    = 5;
    localparam int MC_CRTC14   = 4;
    localparam int EF_TEST     = 7;
    localparam int AX_TRAP     = 7;
    localparam int AX_FIFO     = 6;
    localparam int AX_OVF      = 5;
    localparam int AX_MISC     = 4;

    // ==========================================================
    // Reset values and timing
    localparam logic [7:0] RST_BIT_MASK = 8'hFF;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam int         FIFO_DEPTH   = 4;
    localparam int         FIFO_WAIT    = 3;

    // ==========================================================
    // Emulation modes
    typedef enum logic [1:0] {
        LDEMU_VGA  = 2'b00,
        LDEMU_EGA  = 2'b01,
        LDEMU_CGA  = 2'b10,
        LDEMU_MONO = 2'b11
    } ldemu_mode_type;

    // Host access carrier
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } ldemu_bus_type;

    // Video-side status carrier
    typedef struct packed {
        logic       vretrace;
        logic       dispen_n;
        logic       lpen_sw_open;
        logic [7:0] attr_colour;
    } ldemu_video_type;

    // Palette output carrier
    typedef struct packed {
        logic       blank;
        logic       blink_en;
        logic       gfx;
        logic       hires;
        logic       blue_force;
        logic       blue_from_pixel;
        logic       intensify;
        logic [3:0] colour;
        logic       border_from_attr;
        logic       palette_attr;
    } ldemu_pal_type;

endpackage

//--- hw/ldemu_regs.sv
// Legacy display emulation register bank: control, status, trap and FIFO flags
`timescale 1ns/1ps

module ldemu_regs #(
    parameter int FIFO_DEPTH = ldemu_pkg::FIFO_DEPTH
) (
    input  wire logic                       mclk,
    input  wire logic                       nrst,
    input  wire logic                       clk_en,
    input  wire ldemu_pkg::ldemu_bus_type   bus,
    input  wire ldemu_pkg::ldemu_video_type video,
    input  wire logic [1:0]                 plane_sel,
    input  wire logic                       crtc_wr,
    input  wire logic [4:0]                 crtc_idx,
    input  wire logic [7:0]                 crtc_data,
    input  wire logic                       misc_trap,
    input  wire logic                       fifo_rd,
    output logic [7:0]                      rdata_q,
    output logic [7:0]                      plane_write_bit_mask_q,
    output logic [7:0]                      fifo_data_q,
    output logic                            fifo_ready_q,
    output logic                            trap_q,
    output ldemu_pkg::ldemu_pal_type        pal_q,
    output logic [1:0]                      emul_mode_q,
    output logic                            seq_low_interleave_q,
    output logic                            addr_14bit_q,
    output logic                            test_en_q,
    output logic [7:0]                      test_ctrl_q,
    output logic [1:0]                      feature_q
);

    // ==========================================================
    // Reset synchroniser
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ==========================================================
    // Access decode
    logic acc;
    logic wr;
    logic rd;
    logic [3:0] gc_idx_q;
    logic [3:0] aux_idx_q;
    assign acc = clk_en & (bus.rd | bus.wr);
    assign wr  = clk_en & bus.wr;
    assign rd  = clk_en & bus.rd;

    logic wr_gc_idx;
    logic wr_gc;
    logic wr_cm;
    logic wr_cs;
    logic wr_fc;
    logic wr_ax_idx;
    logic wr_ax;
    logic rd_ax_idx;
    assign wr_gc_idx = wr && bus.addr == ldemu_pkg::OFF_GC_INDEX;
    assign wr_gc     = wr && bus.addr == ldemu_pkg::OFF_GC_DATA;
    assign wr_cm     = wr && bus.addr == ldemu_pkg::OFF_MODE_CTL;
    assign wr_cs     = wr && bus.addr == ldemu_pkg::OFF_COLOUR_SEL;
    assign wr_fc     = wr && bus.addr == ldemu_pkg::OFF_STATUS_ONE;
    assign wr_ax_idx = wr && bus.addr == ldemu_pkg::OFF_AUX_INDEX;
    assign wr_ax     = wr && bus.addr == ldemu_pkg::OFF_AUX_DATA;
    assign rd_ax_idx = rd && bus.addr == ldemu_pkg::OFF_AUX_INDEX;

    // ==========================================================
    // Control registers
    logic [7:0] cm_q;
    logic [7:0] cs_q;
    logic [7:0] mc_q;
    logic [7:0] ef_q;
    logic [7:0] ec_q;
    logic [7:0] st_q;
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gc_idx_q               <= 4'h0;
            aux_idx_q              <= 4'h0;
            plane_write_bit_mask_q <= ldemu_pkg::RST_BIT_MASK;
            cm_q                   <= ldemu_pkg::RST_ZERO;
            cs_q                   <= ldemu_pkg::RST_ZERO;
            mc_q                   <= ldemu_pkg::RST_ZERO;
            ef_q                   <= ldemu_pkg::RST_ZERO;
            ec_q                   <= ldemu_pkg::RST_ZERO;
            st_q                   <= ldemu_pkg::RST_ZERO;
            feature_q              <= 2'b00;
        end else begin
            if (wr_gc_idx) begin
                gc_idx_q <= bus.wdata[3:0];
            end
            if (wr_gc && gc_idx_q == ldemu_pkg::GC_IDX_BIT_MASK) begin
                plane_write_bit_mask_q <= bus.wdata;
            end
            if (wr_cm) begin
                cm_q <= {2'b00, bus.wdata[5:0]};
            end
            if (wr_cs) begin
                cs_q <= {2'b00, bus.wdata[5:0]};
            end
            if (wr_fc) begin
                feature_q <= bus.wdata[1:0];
            end
            if (wr_ax_idx) begin
                aux_idx_q <= bus.wdata[3:0];
            end
            if (wr_ax) begin
                case (aux_idx_q)
                    ldemu_pkg::AUX_IDX_MODE:  mc_q <= bus.wdata;
                    ldemu_pkg::AUX_IDX_EXTFN: ef_q <= bus.wdata;
                    ldemu_pkg::AUX_IDX_EMUL:  ec_q <= bus.wdata;
                    ldemu_pkg::AUX_IDX_STORE: st_q <= bus.wdata;
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // Palette and mode decode
    logic gfx;
    logic g320;
    logic hw_pal;
    always_comb begin
        gfx    = cm_q[ldemu_pkg::CM_GFX];
        g320   = gfx & ~cm_q[ldemu_pkg::CM_HIRES];
        hw_pal = ~ec_q[ldemu_pkg::EC_PALDIS];
    end

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pal_q                <= '0;
            emul_mode_q          <= 2'b00;
            seq_low_interleave_q <= 1'b0;
            addr_14bit_q         <= 1'b0;
            test_en_q            <= 1'b0;
            test_ctrl_q          <= 8'h00;
        end else if (clk_en) begin
            // Blanking only when emulation control permits it
            pal_q.blank <= ~cm_q[ldemu_pkg::CM_DISPEN] & ec_q[ldemu_pkg::EC_BLANK];
            pal_q.blink_en <= cm_q[ldemu_pkg::CM_BLINK];
            pal_q.gfx <= gfx;
            pal_q.hires <= gfx & cm_q[ldemu_pkg::CM_HIRES];
            pal_q.blue_from_pixel <= g320 & hw_pal & cm_q[ldemu_pkg::CM_MONO];
            pal_q.blue_force <= g320 & hw_pal & ~cm_q[ldemu_pkg::CM_MONO]
                                & cs_q[ldemu_pkg::CS_ALTPAL];
            pal_q.intensify <= g320 & hw_pal & ~cs_q[ldemu_pkg::CS_INTPAL];
            pal_q.colour <= hw_pal ? cs_q[3:0] : 4'h0;
            pal_q.border_from_attr <= ec_q[ldemu_pkg::EC_BORDER] | ~hw_pal;
            pal_q.palette_attr <= ~hw_pal;
            emul_mode_q <= mc_q[1:0];
            seq_low_interleave_q <= mc_q[ldemu_pkg::MC_SPEED];
            addr_14bit_q <= mc_q[ldemu_pkg::MC_CRTC14];
            test_en_q <= ef_q[ldemu_pkg::EF_TEST];
            test_ctrl_q <= ef_q[ldemu_pkg::EF_TEST] ? st_q : 8'h00;
        end
    end

    // ==========================================================
    // Light pen latch
    logic lpen_q;
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lpen_q <= 1'b0;
        end else if (acc && bus.addr == ldemu_pkg::OFF_LPEN_SET) begin
            lpen_q <= 1'b1;
        end else if (acc && bus.addr == ldemu_pkg::OFF_LPEN_CLEAR) begin
            lpen_q <= 1'b0;
        end
    end

    // ==========================================================
    // CRTC emulation FIFO, trap and flags
    logic [7:0] fifo_mem_q [FIFO_DEPTH];
    logic [2:0] wcnt_q;
    logic [2:0] rptr_q;
    logic       fifo_hold_q;
    logic       ovf_q;
    logic       trap_ff_q;
    logic       crtc_trap_q;
    logic       misc_q;
    logic [1:0] wait_q;
    logic       crtc_hit;
    // Trap enables live outside this block, so CRTC traps stay armed
    assign crtc_hit = clk_en & crtc_wr
                    & (crtc_idx <= 5'h0B || (crtc_idx >= 5'h10 && crtc_idx <= 5'h18));

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                fifo_mem_q[i] <= 8'h00;
            end
            wcnt_q      <= 3'd0;
            rptr_q      <= 3'd0;
            fifo_hold_q <= 1'b0;
            ovf_q       <= 1'b0;
            crtc_trap_q <= 1'b0;
        end else if (wr_ax_idx && bus.wdata[ldemu_pkg::AX_FIFO]) begin
            fifo_hold_q <= 1'b1;
            wcnt_q      <= 3'd0;
            rptr_q      <= 3'd0;
            ovf_q       <= 1'b0;
            crtc_trap_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_ax_idx) begin
                fifo_hold_q <= 1'b0;
            end
            if (rd_ax_idx) begin
                ovf_q  <= 1'b0;
                rptr_q <= 3'd0;
            end else if (fifo_rd && fifo_ready_q && rptr_q < wcnt_q) begin
                rptr_q <= rptr_q + 3'd1;
                if (rptr_q + 3'd1 == wcnt_q) begin
                    wcnt_q      <= 3'd0;
                    crtc_trap_q <= 1'b0;
                end
            end
            // New write comes last so it wins over a clear in the same cycle
            if (crtc_hit && !fifo_hold_q) begin
                crtc_trap_q <= 1'b1;
                if (wcnt_q < 3'(FIFO_DEPTH)) begin
                    fifo_mem_q[wcnt_q[1:0]] <= crtc_data;
                    wcnt_q <= wcnt_q + 3'd1;
                end else begin
                    ovf_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            trap_ff_q    <= 1'b0;
            trap_q       <= 1'b0;
            misc_q       <= 1'b0;
            wait_q       <= 2'd0;
            fifo_ready_q <= 1'b0;
            fifo_data_q  <= 8'h00;
        end else if (clk_en) begin
            // Raising wins over the clearing read in the same cycle
            if (crtc_hit || misc_trap) begin
                trap_ff_q <= 1'b1;
                trap_q    <= 1'b1;
            end else if (rd_ax_idx) begin
                trap_ff_q <= 1'b0;
                trap_q    <= 1'b0;
            end
            if (misc_trap) begin
                misc_q <= 1'b1;
            end else if (rd_ax_idx) begin
                misc_q <= 1'b0;
            end
            // FIFO readable three clocks after the index read
            if (rd_ax_idx) begin
                wait_q       <= 2'(ldemu_pkg::FIFO_WAIT);
                fifo_ready_q <= 1'b0;
            end else if (wait_q != 2'd0) begin
                wait_q <= wait_q - 2'd1;
                fifo_ready_q <= wait_q == 2'd1;
            end
            fifo_data_q <= fifo_mem_q[rptr_q[1:0]];
        end
    end

    // ==========================================================
    // Read data
    logic       vr_bit;
    logic [1:0] diag;
    always_comb begin
        case (plane_sel)
            2'b00:   diag = {video.attr_colour[2], video.attr_colour[0]};
            2'b01:   diag = {video.attr_colour[5], video.attr_colour[4]};
            2'b10:   diag = {video.attr_colour[3], video.attr_colour[1]};
            default: diag = {video.attr_colour[7], video.attr_colour[6]};
        endcase
        vr_bit = mc_q[1:0] == ldemu_pkg::LDEMU_MONO;
    end

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            case (bus.addr)
                ldemu_pkg::OFF_FEATURE_RD: rdata_q <= {6'h00, feature_q};
                ldemu_pkg::OFF_GC_DATA:
                    rdata_q <= gc_idx_q == ldemu_pkg::GC_IDX_BIT_MASK
                               ? plane_write_bit_mask_q : 8'h00;
                ldemu_pkg::OFF_MODE_CTL:   rdata_q <= cm_q;
                ldemu_pkg::OFF_COLOUR_SEL: rdata_q <= cs_q;
                ldemu_pkg::OFF_STATUS_ONE:
                    rdata_q <= {vr_bit ? ~video.vretrace : 1'b0, 1'b0, diag,
                                vr_bit ? 1'b0 : video.vretrace,
                                video.lpen_sw_open, lpen_q, video.dispen_n};
                ldemu_pkg::OFF_AUX_INDEX:
                    rdata_q <= {trap_ff_q, crtc_trap_q & (wcnt_q != 3'd0),
                                ovf_q & trap_ff_q, misc_q, aux_idx_q};
                ldemu_pkg::OFF_AUX_DATA:
                    case (aux_idx_q)
                        ldemu_pkg::AUX_IDX_MODE:  rdata_q <= mc_q;
                        ldemu_pkg::AUX_IDX_EXTFN: rdata_q <= ef_q;
                        ldemu_pkg::AUX_IDX_EMUL:  rdata_q <= ec_q;
                        ldemu_pkg::AUX_IDX_STORE: rdata_q <= st_q;
                        default:                  rdata_q <= 8'h00;
                    endcase
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Checks
    sequence fifo_settle_s;
        !fifo_ready_q [*3];
    endsequence
    index_read_clears_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        rd_ax_idx && !crtc_hit && !misc_trap |=> !trap_q)
        else $error("trap not cleared by index read");
    trap_holds_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        trap_q && !rd_ax_idx |=> trap_q)
        else $error("trap dropped without index read");
    lpen_set_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        acc && bus.addr == ldemu_pkg::OFF_LPEN_SET |=> lpen_q)
        else $error("light pen latch not set");
    fifo_wait_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        rd_ax_idx |=> fifo_settle_s)
        else $error("fifo ready too early");
    blank_gate_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        clk_en && !ec_q[ldemu_pkg::EC_BLANK] |=> !pal_q.blank)
        else $error("blank without permission");
    mode_follow_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        clk_en |=> emul_mode_q == $past(mc_q[1:0]))
        else $error("mode output mismatch");
    misc_flag_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        clk_en && misc_trap |=> misc_q)
        else $error("misc trap flag not set");
    crtc_trap_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        crtc_hit && !fifo_hold_q && !wr_ax_idx |=> trap_q && crtc_trap_q)
        else $error("crtc write raised no trap");
    fifo_reset_a: assert property (@(posedge mclk) disable iff (!rst_n_q)
        wr_ax_idx && bus.wdata[ldemu_pkg::AX_FIFO] |=> wcnt_q == 3'd0 && !ovf_q)
        else $error("fifo reset incomplete");

endmodule

//--- tb/ldemu_host.sv
// Host processor model: byte reads and writes on the memory-mapped register bus
`timescale 1ns/1ps

module ldemu_host (
    input  wire logic              mclk,
    input  wire logic [7:0]        rdata,
    output ldemu_pkg::ldemu_bus_type bus
);
    // ==========================================================
    // Bus cycles
    initial bus = '0;

    // Released address and data lines never keep the last value
    task automatic idle();
        bus.rd    = 1'b0;
        bus.wr    = 1'b0;
        bus.addr  = ~bus.addr;
        bus.wdata = ~bus.wdata;
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(negedge mclk);
        bus.rd    = 1'b0;
        bus.wr    = 1'b1;
        bus.addr  = a;
        bus.wdata = d;
        @(negedge mclk);
        idle();
    endtask

    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        @(negedge mclk);
        bus.rd   = 1'b1;
        bus.wr   = 1'b0;
        bus.addr = a;
        @(negedge mclk);
        d = rdata;
        idle();
    endtask

    task automatic aux_wr(input logic [3:0] idx, input logic [7:0] d);
        wr(ldemu_pkg::OFF_AUX_INDEX, {4'h0, idx});
        wr(ldemu_pkg::OFF_AUX_DATA, d);
    endtask

    // Index read, then the settle time the FIFO needs
    task automatic index_rd(output logic [7:0] d);
        rd(ldemu_pkg::OFF_AUX_INDEX, d);
        repeat (ldemu_pkg::FIFO_WAIT) @(negedge mclk);
    endtask

    // Reset pulse must be lowered again before reuse
    task automatic fifo_reset();
        wr(ldemu_pkg::OFF_AUX_INDEX, 8'h40);
        wr(ldemu_pkg::OFF_AUX_INDEX, 8'h00);
    endtask
endmodule

//--- tb/tb.sv
// Self-checking testbench for the legacy display emulation register bank
`timescale 1ns/1ps

module tb;
    logic mclk = 1'b0;
    logic nrst, clk_en, crtc_wr, misc_trap, fifo_rd, trap, fifo_ready, seq_low, a14, test_en;
    logic [1:0] plane_sel, emul, feature;
    logic [4:0] crtc_idx;
    logic [7:0] crtc_data, rdata, mask, fifo_data, test_ctrl, d, a;
    ldemu_pkg::ldemu_bus_type   bus;
    ldemu_pkg::ldemu_video_type video;
    ldemu_pkg::ldemu_pal_type   pal;
    int err_count = 0;
    int tests_run = 0;

    always #20 mclk = ~mclk;

    ldemu_host host (.mclk(mclk), .rdata(rdata), .bus(bus));

    ldemu_regs dut (
        .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .bus(bus), .video(video),
        .plane_sel(plane_sel), .crtc_wr(crtc_wr), .crtc_idx(crtc_idx),
        .crtc_data(crtc_data), .misc_trap(misc_trap), .fifo_rd(fifo_rd),
        .rdata_q(rdata), .plane_write_bit_mask_q(mask), .fifo_data_q(fifo_data),
        .fifo_ready_q(fifo_ready), .trap_q(trap), .pal_q(pal), .emul_mode_q(emul),
        .seq_low_interleave_q(seq_low), .addr_14bit_q(a14), .test_en_q(test_en),
        .test_ctrl_q(test_ctrl), .feature_q(feature)
    );

    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        #(40 * 20000);
        err_count++;
        summarize();
    end

    // ==========================================================
    // Tests
    initial begin
        nrst = 1'b0; clk_en = 1'b1; video = '0; plane_sel = 2'h0; crtc_wr = 1'b0;
        crtc_idx = 5'h00; crtc_data = 8'h00; misc_trap = 1'b0; fifo_rd = 1'b0;
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        repeat (3) @(negedge mclk);
        chk(mask, 8'hFF);
        host.wr(ldemu_pkg::OFF_GC_INDEX, {4'h0, ldemu_pkg::GC_IDX_BIT_MASK});
        host.wr(ldemu_pkg::OFF_GC_DATA, 8'h5A);
        chk(mask, 8'h5A);
        // Derived outputs trail the register write by one clock
        host.aux_wr(ldemu_pkg::AUX_IDX_MODE, 8'h32);
        @(negedge mclk);
        chk({seq_low, a14, 4'h0, emul}, 8'hC2);
        host.aux_wr(ldemu_pkg::AUX_IDX_EXTFN, 8'h80);
        @(negedge mclk);
        chk({7'h0, test_en}, 8'h01);
        host.aux_wr(ldemu_pkg::AUX_IDX_STORE, 8'hA5);
        @(negedge mclk);
        chk(test_ctrl, 8'hA5);
        host.rd(ldemu_pkg::OFF_AUX_INDEX, d);
        chk(d & 8'h0F, 8'h04);
        host.rd(ldemu_pkg::OFF_AUX_DATA, d);
        chk(d, 8'hA5);
        // Blanking allowed, attribute palette and border
        host.aux_wr(ldemu_pkg::AUX_IDX_EMUL, 8'h38);
        host.wr(ldemu_pkg::OFF_MODE_CTL, 8'h32);
        host.wr(ldemu_pkg::OFF_COLOUR_SEL, 8'h0C);
        chk({2'b0, pal.blank, pal.blink_en, pal.gfx, pal.hires, pal.border_from_attr,
             pal.palette_attr}, 8'h3F);
        host.aux_wr(ldemu_pkg::AUX_IDX_EMUL, 8'h00);
        @(negedge mclk);
        chk({pal.blank, pal.border_from_attr, pal.palette_attr, 1'b0, pal.colour},
            8'h0C);
        host.wr(ldemu_pkg::OFF_MODE_CTL, 8'h22);
        host.wr(ldemu_pkg::OFF_COLOUR_SEL, 8'h20);
        @(negedge mclk);
        chk({5'h0, pal.blue_force, pal.blue_from_pixel, pal.intensify}, 8'h05);
        host.wr(ldemu_pkg::OFF_MODE_CTL, 8'h26);
        @(negedge mclk);
        chk({7'h0, pal.blue_from_pixel}, 8'h01);
        host.wr(ldemu_pkg::OFF_STATUS_ONE, 8'h02);
        host.rd(ldemu_pkg::OFF_FEATURE_RD, d);
        chk({d[7:2], feature}, 8'h02);
        host.rd(13'h1FD0, d);
        chk(d, 8'h00);
        // ==========================================================
        // Status port and light pen latch
        a = 8'hA5;
        video = {1'b1, 1'b1, 1'b1, a};
        host.wr(ldemu_pkg::OFF_LPEN_SET, 8'h00);
        for (int p = 0; p < 4; p++) begin
            plane_sel = p[1:0];
            host.rd(ldemu_pkg::OFF_STATUS_ONE, d);
            chk(d & 8'h3F, {2'b0, (p == 0) ? {a[2], a[0]} : (p == 1) ? {a[5], a[4]} :
                (p == 2) ? {a[3], a[1]} : {a[7], a[6]}, 4'hF});
        end
        host.rd(ldemu_pkg::OFF_LPEN_CLEAR, d);
        host.rd(ldemu_pkg::OFF_STATUS_ONE, d);
        chk(d & 8'h02, 8'h00);
        host.rd(ldemu_pkg::OFF_LPEN_SET, d);
        host.rd(ldemu_pkg::OFF_STATUS_ONE, d);
        chk(d & 8'h02, 8'h02);
        host.wr(ldemu_pkg::OFF_LPEN_CLEAR, 8'hFF);
        host.aux_wr(ldemu_pkg::AUX_IDX_MODE, 8'h03);
        @(negedge mclk);
        chk({seq_low, a14, 4'h0, emul}, 8'h03);
        host.rd(ldemu_pkg::OFF_STATUS_ONE, d);
        chk(d & 8'h87, 8'h05);
        video = {1'b0, 1'b0, 1'b0, a};
        host.rd(ldemu_pkg::OFF_STATUS_ONE, d);
        chk(d & 8'h85, 8'h80);
        // ==========================================================
        // Traps, overflow and FIFO
        for (int i = 0; i < 5; i++) begin
            @(negedge mclk);
            crtc_wr = 1'b1;
            crtc_idx = 5'(i + 1);
            crtc_data = 8'h10 + 8'(i);
        end
        @(negedge mclk);
        crtc_wr = 1'b0;
        repeat (3) @(negedge mclk);
        chk({7'h0, trap}, 8'h01);
        host.index_rd(d);
        chk(d & 8'hF0, 8'hE0);
        chk({fifo_ready, trap, 6'h0}, 8'h80);
        host.index_rd(d);
        chk(d & 8'hF0, 8'h40);
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            fifo_rd = 1'b1;
            @(negedge mclk);
            fifo_rd = 1'b0;
            chk(fifo_data, 8'h10 + 8'(i));
        end
        host.index_rd(d);
        chk(d & 8'h40, 8'h00);
        @(negedge mclk);
        misc_trap = 1'b1;
        @(negedge mclk);
        misc_trap = 1'b0;
        chk({7'h0, trap}, 8'h01);
        host.index_rd(d);
        chk(d & 8'hF0, 8'h90);
        // Reset flushes, zero write lets it fill again
        for (int k = 0; k < 2; k++) begin
            @(negedge mclk);
            crtc_wr = 1'b1;
            crtc_idx = 5'h12;
            @(negedge mclk);
            crtc_wr = 1'b0;
            if (k == 0) begin
                host.fifo_reset();
            end
            host.index_rd(d);
            chk(d & 8'h60, (k == 0) ? 8'h00 : 8'h40);
        end
        summarize();
    end
endmodule
